// File: rtl/conv_ctrl_map.svh
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH
`define OFS_CONTROL 8'hC5
`define OFS_RESULT 8'hC6
`define OFS_SAMPLE 8'hC7
`define OFS_PORT 8'hC8
`define BIT_DONE 4
`define BIT_BUSY 3
`define CTRL_RESET 5'h00
`define OSC_PER_MC 4'hC
`define CONV_MC 6'h28
`define SAMPLE_MC 6'h08
`define IRQ_VECTOR 8'h2B
`endif

// File: rtl/conv_ctrl_pkg.sv
package conv_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b100
   } conv_state_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
endpackage : conv_ctrl_pkg

// File: rtl/conv_ctrl.sv
`timescale 1ns/1ps
`include "conv_ctrl_map.svh"
module conv_ctrl #(
   parameter int DATA_W = 8
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic IRQ_EN_I,
   input wire logic IDLE_I,
   input wire logic PDOWN_I,
   input wire logic [7:0] PIN_I,
   input wire logic [DATA_W-1:0] CODE_I,
   output logic [7:0] RDATA_O,
   output logic IRQ_O,
   output logic [7:0] IRQ_VEC_O,
   output logic [7:0] PORT_O,
   output logic SAMPLE_O,
   output logic [2:0] MUX_O
);
   conv_ctrl_pkg::bus_req_t req;
   conv_ctrl_pkg::conv_state_t state_r;
   logic [3:0] osc_r;
   logic mc_tick;
   logic [5:0] mc_cnt_r;
   logic [2:0] chan_r;
   logic busy_r;
   logic done_r;
   logic [DATA_W-1:0] result_r;
   logic [7:0] dis_r;
   logic [7:0] dis_nxt;
   logic ctrl_wr;
   logic start;
   logic finish;
   logic abort;
   logic [9:0] busy_len_r;

   assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
   assign ctrl_wr = req.wr && (req.addr == `OFS_CONTROL);
   assign start = ctrl_wr && req.wdata[`BIT_BUSY] && !busy_r && !done_r && !abort;
   assign abort = IDLE_I || PDOWN_I;
   assign mc_tick = (osc_r == `OSC_PER_MC - 4'h1);
   assign finish = busy_r && mc_tick && (mc_cnt_r == `CONV_MC - 6'h01) && !abort;

   // Machine cycle divider
   always_ff @(posedge CLK_I)
   begin
      if (RST_I || start)
         osc_r <= 4'h0;
      else if (mc_tick)
         osc_r <= 4'h0;
      else
         osc_r <= osc_r + 4'h1;
   end

   // Sequencer
   always_ff @(posedge CLK_I)
   begin
      if (RST_I || abort)
      begin
         state_r <= conv_ctrl_pkg::ST_IDLE;
         mc_cnt_r <= 6'h00;
      end
      else
      begin
         case (state_r)
            conv_ctrl_pkg::ST_IDLE:
               if (start)
               begin
                  state_r <= conv_ctrl_pkg::ST_SAMPLE;
                  mc_cnt_r <= 6'h00;
               end
            conv_ctrl_pkg::ST_SAMPLE:
               if (mc_tick)
               begin
                  mc_cnt_r <= mc_cnt_r + 6'h01;
                  if (mc_cnt_r == `SAMPLE_MC - 6'h01)
                     state_r <= conv_ctrl_pkg::ST_CONVERT;
               end
            conv_ctrl_pkg::ST_CONVERT:
               if (finish)
                  state_r <= conv_ctrl_pkg::ST_IDLE;
               else if (mc_tick)
                  mc_cnt_r <= mc_cnt_r + 6'h01;
            default:
               state_r <= conv_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   // Busy bit
   always_ff @(posedge CLK_I)
   begin
      if (RST_I || abort || finish)
         busy_r <= 1'b0;
      else if (start)
         busy_r <= 1'b1;
   end

   // Done flag; hardware set wins over software clear
   always_ff @(posedge CLK_I)
   begin
      if (RST_I || PDOWN_I)
         done_r <= 1'b0;
      else if (finish)
         done_r <= 1'b1;
      else if (ctrl_wr && !req.wdata[`BIT_DONE])
         done_r <= 1'b0;
   end

   // Channel field
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         chan_r <= 3'h0;
      else if (ctrl_wr && !busy_r && !done_r)
         chan_r <= req.wdata[2:0];
   end

   // Result register
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         result_r <= '0;
      else if (finish)
         result_r <= CODE_I;
   end

   // Buffer disable, latched at start only
   always_comb
   begin
      dis_nxt = 8'h00;
      dis_nxt[req.wdata[2:0]] = 1'b1;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         dis_r <= 8'h00;
      else if (start)
         dis_r <= dis_nxt;
   end

   // Port read view
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         PORT_O <= 8'hFF;
      else
         PORT_O <= PIN_I | dis_r;
   end

   // Analog side outputs
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         SAMPLE_O <= 1'b0;
         MUX_O <= 3'h0;
      end
      else
      begin
         SAMPLE_O <= (state_r == conv_ctrl_pkg::ST_SAMPLE) && !abort;
         MUX_O <= chan_r;
      end
   end

   // Interrupt request
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         IRQ_O <= 1'b0;
         IRQ_VEC_O <= `IRQ_VECTOR;
      end
      else
      begin
         IRQ_O <= done_r && IRQ_EN_I;
         IRQ_VEC_O <= `IRQ_VECTOR;
      end
   end

   // Read data, one cycle after read strobe
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         RDATA_O <= 8'h00;
      else if (!req.rd)
         RDATA_O <= 8'h00;
      else if (req.addr == `OFS_CONTROL)
         RDATA_O <= {3'h0, done_r, busy_r, chan_r};
      else if (req.addr == `OFS_RESULT)
         RDATA_O <= result_r;
      else if (req.addr == `OFS_PORT)
         RDATA_O <= PIN_I | dis_r;
      else
         RDATA_O <= 8'h00;
   end

   // Clocks spent busy, for the conversion time checks
   always_ff @(posedge CLK_I)
   begin
      if (RST_I || !busy_r)
         busy_len_r <= 10'h000;
      else
         busy_len_r <= busy_len_r + 10'h001;
   end

   // Handshake and status bits
   AST_EXCL: assert property (@(posedge CLK_I) disable iff (RST_I)
      !(busy_r && done_r))
      else $error("busy and done both set");
   AST_START: assert property (@(posedge CLK_I) disable iff (RST_I)
      start |=> busy_r && !done_r)
      else $error("start did not set busy");
   AST_BUSY_ZERO: assert property (@(posedge CLK_I) disable iff (RST_I)
      (ctrl_wr && !req.wdata[`BIT_BUSY] && busy_r && !abort && !finish) |=> busy_r)
      else $error("software cleared busy");
   AST_BUSY_STATE: assert property (@(posedge CLK_I) disable iff (RST_I)
      busy_r == (state_r != conv_ctrl_pkg::ST_IDLE))
      else $error("busy and sequencer disagree");
   AST_ONEHOT: assert property (@(posedge CLK_I) disable iff (RST_I)
      $onehot(state_r))
      else $error("sequencer state not one-hot");
   AST_DONE_CLR: assert property (@(posedge CLK_I) disable iff (RST_I)
      (ctrl_wr && !req.wdata[`BIT_DONE] && !finish) |=> !done_r)
      else $error("done not cleared by write");

   // Conversion timing, 40 machine cycles of 12 clocks
   AST_LEN: assert property (@(posedge CLK_I) disable iff (RST_I)
      start ##1 (!abort) [*8] |-> busy_r)
      else $error("conversion ended early");
   AST_LEN_EXACT: assert property (@(posedge CLK_I) disable iff (RST_I)
      finish |-> busy_len_r == 10'h1DF)
      else $error("conversion length wrong");
   AST_LEN_MAX: assert property (@(posedge CLK_I) disable iff (RST_I)
      busy_r |-> busy_len_r <= 10'h1DF)
      else $error("conversion overran");
   AST_OSC_RANGE: assert property (@(posedge CLK_I) disable iff (RST_I)
      osc_r < `OSC_PER_MC)
      else $error("machine cycle divider out of range");
   AST_SAMPLE_BUSY: assert property (@(posedge CLK_I) disable iff (RST_I)
      SAMPLE_O |-> busy_r)
      else $error("sampling outside conversion");
   AST_SAMPLE_WIN: assert property (@(posedge CLK_I) disable iff (RST_I)
      (busy_r && busy_len_r >= 10'h001 && busy_len_r <= 10'h060) |-> SAMPLE_O)
      else $error("sampling switch open too soon");
   AST_SAMPLE_END: assert property (@(posedge CLK_I) disable iff (RST_I)
      (busy_len_r > 10'h060) |-> !SAMPLE_O)
      else $error("sampling switch closed too long");

   // Completion and result
   AST_FIN: assert property (@(posedge CLK_I) disable iff (RST_I)
      finish |=> done_r && !busy_r && result_r == $past(CODE_I))
      else $error("completion not atomic");
   AST_HOLD: assert property (@(posedge CLK_I) disable iff (RST_I)
      done_r && $past(done_r) |-> $stable(result_r))
      else $error("result changed while done");
   AST_RESULT_RO: assert property (@(posedge CLK_I) disable iff (RST_I)
      (req.wr && req.addr == `OFS_RESULT && !finish) |=> $stable(result_r))
      else $error("result written by software");
   AST_IRQ: assert property (@(posedge CLK_I) disable iff (RST_I)
      (done_r && IRQ_EN_I) |=> IRQ_O)
      else $error("interrupt missing");
   AST_IRQ_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
      !(done_r && IRQ_EN_I) |=> !IRQ_O)
      else $error("spurious interrupt");
   AST_VEC: assert property (@(posedge CLK_I) disable iff (RST_I)
      IRQ_VEC_O == `IRQ_VECTOR)
      else $error("wrong interrupt vector");

   // Channel field and blocking
   AST_BLOCK: assert property (@(posedge CLK_I) disable iff (RST_I)
      (ctrl_wr && (busy_r || done_r)) |=> $stable(chan_r))
      else $error("channel changed while locked");
   AST_START_SEL: assert property (@(posedge CLK_I) disable iff (RST_I)
      start |=> chan_r == $past(req.wdata[2:0]))
      else $error("start did not take channel");
   AST_MUX: assert property (@(posedge CLK_I) disable iff (RST_I)
      1'b1 |=> MUX_O == $past(chan_r))
      else $error("mux select not channel field");

   // Abort and low power modes
   AST_ABORT: assert property (@(posedge CLK_I) disable iff (RST_I)
      abort |=> !busy_r)
      else $error("abort left busy");
   AST_NO_RESULT: assert property (@(posedge CLK_I) disable iff (RST_I)
      (abort && busy_r) |=> !done_r && $stable(result_r))
      else $error("aborted conversion gave result");
   AST_PD: assert property (@(posedge CLK_I) disable iff (RST_I)
      PDOWN_I |=> !done_r)
      else $error("done survived power-down");
   AST_IDLE_KEEP: assert property (@(posedge CLK_I) disable iff (RST_I)
      (IDLE_I && !PDOWN_I && done_r && !(ctrl_wr && !req.wdata[`BIT_DONE])) |=> done_r)
      else $error("done lost on idle");

   // Digital buffer disable and port view
   AST_DIS_ONEHOT: assert property (@(posedge CLK_I) disable iff (RST_I)
      start |=> dis_r == (8'h01 << $past(req.wdata[2:0])))
      else $error("disable mask not selected pin");
   AST_DIS_KEEP: assert property (@(posedge CLK_I) disable iff (RST_I)
      !start |=> $stable(dis_r))
      else $error("disable mask changed without start");
   AST_SEL: assert property (@(posedge CLK_I) disable iff (RST_I)
      ##1 (PORT_O | ~$past(dis_r)) == 8'hFF)
      else $error("disabled pin not one");
   AST_PORT_UNSEL: assert property (@(posedge CLK_I) disable iff (RST_I)
      1'b1 |=> ((PORT_O ^ $past(PIN_I)) & ~$past(dis_r)) == 8'h00)
      else $error("enabled pin level wrong");

   // Register reads
   AST_RD_IDLE: assert property (@(posedge CLK_I) disable iff (RST_I)
      !req.rd |=> RDATA_O == 8'h00)
      else $error("read data without read");
   AST_RD_CTRL: assert property (@(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == `OFS_CONTROL) |=> RDATA_O[7:5] == 3'h0)
      else $error("unused control bits not zero");
   AST_RD_RESULT: assert property (@(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == `OFS_RESULT) |=> RDATA_O == $past(result_r))
      else $error("result read wrong");
   AST_RD_PORT: assert property (@(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == `OFS_PORT) |=> RDATA_O == ($past(PIN_I) | $past(dis_r)))
      else $error("port read wrong");

   COV_CONV: cover property (@(posedge CLK_I) finish);
   COV_BLOCKED: cover property (@(posedge CLK_I) ctrl_wr && req.wdata[`BIT_BUSY] && busy_r);
   COV_ABORT: cover property (@(posedge CLK_I) busy_r && IDLE_I);
   COV_IDLE_DONE: cover property (@(posedge CLK_I) done_r && IDLE_I);
   COV_PDOWN_DONE: cover property (@(posedge CLK_I) done_r && PDOWN_I);
endmodule : conv_ctrl

// File: verif/analog_src.sv
`timescale 1ns/1ps
module analog_src (
   input wire logic [2:0] mux_i,
   input wire logic [7:0] level_i,
   output logic [7:0] pin_o,
   output logic [7:0] code_o
);
   // Pins show the levels the bench sets, code tracks the routed channel
   assign pin_o = level_i;
   assign code_o = {5'h1A, mux_i};
endmodule : analog_src

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic CLK_I, RST_I, WR_I, RD_I, IRQ_EN_I, IDLE_I, PDOWN_I, IRQ_O, SAMPLE_O;
   logic [7:0] ADDR_I, WDATA_I, PIN_I, CODE_I, RDATA_O, IRQ_VEC_O, PORT_O, lvl, d;
   logic [2:0] MUX_O, c;
   int n_fail, num_checks, samp_n, cyc, t0, s0;
   conv_ctrl conv_ctrl_i (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WR_I(WR_I), .RD_I(RD_I), .IRQ_EN_I(IRQ_EN_I), .IDLE_I(IDLE_I), .PDOWN_I(PDOWN_I),
      .PIN_I(PIN_I), .CODE_I(CODE_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
      .IRQ_VEC_O(IRQ_VEC_O), .PORT_O(PORT_O), .SAMPLE_O(SAMPLE_O), .MUX_O(MUX_O));
   analog_src analog_src_i (.mux_i(MUX_O), .level_i(lvl), .pin_o(PIN_I), .code_o(CODE_I));
   initial
   begin
      CLK_I = 1'b0;
      forever #5 CLK_I = ~CLK_I;
   end
   always @(posedge CLK_I)
   begin
      cyc <= cyc + 1;
      if (SAMPLE_O === 1'b1)
         samp_n <= samp_n + 1;
   end
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         n_fail++;
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= v;
      WR_I <= 1'b1;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 d = RDATA_O;
   endtask : rd
   task wait_done;
      int k;
      k = 0;
      d = 8'h00;
      while (d[4] !== 1'b1 && k < 700)
      begin
         rd(8'hC5);
         k++;
      end
   endtask : wait_done
   task mode_pulse(input logic pd);
      @(posedge CLK_I);
      IDLE_I <= ~pd;
      PDOWN_I <= pd;
      @(posedge CLK_I);
      IDLE_I <= 1'b0;
      PDOWN_I <= 1'b0;
   endtask : mode_pulse
   initial
   begin
      n_fail = 0;
      num_checks = 0;
      cyc = 0;
      samp_n = 0;
      RST_I = 1'b1;
      {WR_I, RD_I, IRQ_EN_I, IDLE_I, PDOWN_I} = 5'h00;
      ADDR_I = 8'h00;
      WDATA_I = 8'h00;
      lvl = 8'h5A;
      repeat (16) @(posedge CLK_I);
      RST_I <= 1'b0;
      rd(8'hC5);
      chk("ctrl_reset", 8'h00, d & 8'h1F);
      chk("port_reset", 8'h5A, PORT_O);
      chk("vector", 8'h2B, IRQ_VEC_O);
      rd(8'h00);
      chk("unmapped", 8'h00, d);
      $display("test reset finished");
      for (int ch = 0; ch < 8; ch++)
      begin
         c = ch[2:0];
         IRQ_EN_I <= c[0];
         s0 = samp_n;
         wr(8'hC5, {5'h01, c});
         t0 = cyc;
         wr(8'hC5, {5'h1C, ~c});
         rd(8'hC5);
         chk("ctrl_busy", {5'h01, c}, d);
         chk("mux", {5'h00, c}, {5'h00, MUX_O});
         chk("port_sel", 8'h5A | (8'h01 << c), PORT_O);
         rd(8'hC8);
         chk("port_read", 8'h5A | (8'h01 << c), d);
         wait_done;
         chk("conv_len", 8'h01, {7'h00, (cyc - t0) >= 476 && (cyc - t0) <= 486});
         chk("sample_len", 8'h60, 8'(samp_n - s0));
         chk("ctrl_done", {5'h02, c}, d);
         rd(8'hC6);
         chk("result", {5'h1A, c}, d);
         chk("irq", {7'h00, c[0]}, {7'h00, IRQ_O});
         wr(8'hC5, {5'h03, ~c});
         wr(8'hC6, 8'h00);
         rd(8'hC6);
         chk("result_hold", {5'h1A, c}, d);
         rd(8'hC5);
         chk("ctrl_block", {5'h02, c}, d);
         wr(8'hC5, 8'h00);
         rd(8'hC5);
         chk("ctrl_clear", {5'h00, c}, d);
      end
      $display("test channels finished");
      for (int m = 0; m < 2; m++)
      begin
         wr(8'hC5, 8'h0A);
         repeat (20) @(posedge CLK_I);
         mode_pulse(m[0]);
         repeat (500) @(posedge CLK_I);
         rd(8'hC5);
         chk("abort_ctrl", 8'h02, d);
         rd(8'hC6);
         chk("abort_result", 8'hD7, d);
      end
      $display("test abort finished");
      wr(8'hC5, 8'h0B);
      wait_done;
      mode_pulse(1'b0);
      rd(8'hC5);
      chk("idle_keep", 8'h13, d);
      mode_pulse(1'b1);
      rd(8'hC5);
      chk("pdown_lose", 8'h00, d & 8'h18);
      $display("test modes finished");
      close_out;
   end
   initial
   begin
      repeat (20000) @(posedge CLK_I);
      n_fail++;
      close_out;
   end
endmodule : testbench
